/* File: tect_params.svh */
// Register offsets, field positions, reset values and timing counts
// for the three-counter timer block. Definitions only.
`ifndef TECT_PARAMS_SVH
`define TECT_PARAMS_SVH

// Register indexes (printed offsets are indexes, address is four times)
`define TECT_IDX_C0_HIGH 8'h0c
`define TECT_IDX_C0_LOW 8'h0d
`define TECT_IDX_C0_CTRL 8'h0e
`define TECT_IDX_C1_HIGH 8'h0f
`define TECT_IDX_C1_LOW 8'h10
`define TECT_IDX_C1_CTRL 8'h11
`define TECT_IDX_C2_VALUE 8'h2c
`define TECT_IDX_C2_CTRL 8'h2d
`define TECT_IDX_FLAGS 8'h30

// Control field positions
`define TECT_PSC_LSB 0
`define TECT_EDGE_BIT 3
`define TECT_RUN_BIT 4
`define TECT_MODE_LSB 6

// Control reset value and writable bits per counter
`define TECT_CTRL_RESET 8'h08
`define TECT_CTRL_MASK_PSC 8'hdf
`define TECT_CTRL_MASK_NOPSC 8'hd8

// Flag register bit positions
`define TECT_FLAG0_BIT 5
`define TECT_FLAG1_BIT 6
`define TECT_FLAG2_BIT 4

// Fixed divider for the second counter's internal source
`define TECT_C1_DIV 4

// AXI responses
`define TECT_RESP_OKAY 2'b00
`define TECT_RESP_SLVERR 2'b10

`endif

/* File: tect_pkg.sv */
// Types for the three-counter timer block.
// Assumes tect_params.svh supplies the numeric constants.
package tect_pkg;

    typedef enum logic [1:0]
    {
        MODE_UNUSED,
        MODE_EVENT,
        MODE_TIMER,
        MODE_PULSE
    } tect_mode_t;

    typedef struct packed
    {
        tect_mode_t mode;
        logic       spare;
        logic       run;
        logic       edge_sel;
        logic [2:0] psc;
    } tect_ctrl_t;

    typedef struct packed
    {
        logic        valid;
        logic [31:0] addr;
    } tect_req_t;

endpackage

/* File: tect_top.sv */
// Three count-up timer/event counters with an AXI4-Lite register slave.
// Assumes the pins are synchronous-ish levels from the chip pads and
// that the bus master keeps valid and payload stable until taken.
// How it works
// RULE1 - Counter 0: 16 bits, system clock source
// RULE2 - Counter 1: 16 bits, clock divided four
// RULE3 - Counter 2: 8 bits, system clock source
// RULE4 - Low byte write fills buffer only
// RULE5 - High write moves both bytes, preload
// RULE6 - High read latches live low byte
// RULE7 - Low read returns the buffer
// RULE8 - Counter 2 write preloads, read live
// RULE9 - Control holds mode, run, edge
// RULE10 - Event mode counts pin edges
// RULE11 - Timer mode counts internal source
// RULE12 - Pulse mode counts during input level
// RULE13 - 16-bit counters run up to all ones
// RULE14 - 8-bit counter runs up to FFh
// RULE15 - Overflow reloads and sets own flag
// RULE16 - Pulse ends at level return, run cleared
// RULE17 - One measurement until run set again
// RULE18 - Pulse start needs an edge
// RULE19 - Pulse overflow reloads and flags too
// RULE20 - Mode codes 01 event, 10 timer, 11 pulse
// RULE21 - Event edge bit 1 falling, 0 rising
// RULE22 - Stopped counter loads with preload write
// RULE23 - Prescaler divides by 1 to 128
// RULE24 - Pin edges synchronized before use
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "tect_params.svh"

module tect_top
    import tect_pkg::*;
#(
    parameter int CW0 = 16,
    parameter int CW2 = 8
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Counter input pins
    input wire logic [2:0] CNT_PIN,
    // Counter values and overflow pulses seen by the chip
    output logic [CW0-1:0] COUNT0,
    output logic [CW0-1:0] COUNT1,
    output logic [CW2-1:0] COUNT2,
    output logic [2:0] OVERFLOW,
    // AXI4-Lite write address
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [31:0] AWADDR,
    // AXI4-Lite write data
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    // AXI4-Lite write response
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read address
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [31:0] ARADDR,
    // AXI4-Lite read data
    output logic RVALID,
    input wire logic RREADY,
    output logic [31:0] RDATA,
    output logic [1:0] RRESP
);

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam int NREG = 9;

    // Returns a one-hot register select, zero when unmapped
    function automatic logic [NREG-1:0] decode(input logic [31:0] a);
        logic [NREG-1:0] s;
        s = '0;
        if (a[1:0] == 2'b00 && a[31:10] == 22'h00_0000)
        begin
            case (a[9:2])
                `TECT_IDX_C0_HIGH: s[0] = 1'b1;
                `TECT_IDX_C0_LOW: s[1] = 1'b1;
                `TECT_IDX_C0_CTRL: s[2] = 1'b1;
                `TECT_IDX_C1_HIGH: s[3] = 1'b1;
                `TECT_IDX_C1_LOW: s[4] = 1'b1;
                `TECT_IDX_C1_CTRL: s[5] = 1'b1;
                `TECT_IDX_C2_VALUE: s[6] = 1'b1;
                `TECT_IDX_C2_CTRL: s[7] = 1'b1;
                `TECT_IDX_FLAGS: s[8] = 1'b1;
                default: s = '0;
            endcase
        end
        return s;
    endfunction

    // ------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------
    tect_req_t aw_q;
    logic w_have_q;
    logic [7:0] wbyte_q;
    logic wlane_q;
    logic [NREG-1:0] wsel;
    logic wr_go;

    assign wsel = decode(aw_q.addr);
    assign wr_go = aw_q.valid && w_have_q && !BVALID;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            aw_q <= '0;
            w_have_q <= 1'b0;
            wbyte_q <= 8'h00;
            wlane_q <= 1'b0;
            AWREADY <= 1'b0;
            WREADY <= 1'b0;
            BVALID <= 1'b0;
            BRESP <= `TECT_RESP_OKAY;
        end
        else
        begin
            AWREADY <= !aw_q.valid && !AWREADY && !BVALID;
            WREADY <= !w_have_q && !WREADY && !BVALID;
            if (AWVALID && AWREADY)
            begin
                aw_q.valid <= 1'b1;
                aw_q.addr <= AWADDR;
            end
            if (WVALID && WREADY)
            begin
                w_have_q <= 1'b1;
                wbyte_q <= WDATA[7:0];
                wlane_q <= WSTRB[0];
            end
            if (wr_go)
            begin
                aw_q.valid <= 1'b0;
                w_have_q <= 1'b0;
                BVALID <= 1'b1;
                BRESP <= (wsel == '0) ? `TECT_RESP_SLVERR
                                      : `TECT_RESP_OKAY;
            end
            else if (BVALID && BREADY)
            begin
                BVALID <= 1'b0;
            end
        end
    end

    // Byte lane 0 must be enabled for a register to change
    logic [NREG-1:0] wr_hit;
    assign wr_hit = (wr_go && wlane_q) ? wsel : '0;

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    logic [NREG-1:0] rsel;
    logic rd_go;

    assign rsel = decode(ARADDR);
    assign rd_go = ARVALID && ARREADY;

    // ------------------------------------------------------------
    // Prescaler and input synchronisers
    // ------------------------------------------------------------
    logic [6:0] psc_q;
    logic [1:0] div4_q;
    logic [2:0] pin_s1_q;
    logic [2:0] pin_s2_q;
    logic [2:0] pin_s3_q;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            psc_q <= 7'h00;
            div4_q <= 2'h0;
        end
        else
        begin
            psc_q <= psc_q + 7'h01;
            div4_q <= div4_q + 2'h1;
        end
    end

    // RULE24 synchronise pin inputs
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            pin_s3_q <= 3'h0;
        end
        else
        begin
            pin_s1_q <= CNT_PIN;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    // RULE23 prescaler tap enable
    function automatic logic psc_tick(input logic [2:0] code,
                                      input logic [6:0] cnt);
        logic [6:0] m;
        m = 7'(8'h01 << code) - 7'h01;
        return (cnt & m) == m;
    endfunction

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    tect_ctrl_t ctrl_q [3];
    logic [15:0] cnt_q [3];
    logic [15:0] pre_q [3];
    logic [7:0] lowbuf_q [2];
    logic [2:0] flag_q;
    logic [2:0] armed_q;
    logic [2:0] tick;
    logic [2:0] pin_rise;
    logic [2:0] pin_fall;

    assign pin_rise = pin_s2_q & ~pin_s3_q;
    assign pin_fall = ~pin_s2_q & pin_s3_q;

    // Register index for each counter's value, low, control
    localparam int HI_IDX [3] = '{0, 3, 6};
    localparam int CT_IDX [3] = '{2, 5, 7};
    localparam logic [15:0] TOP [3] = '{16'hffff, 16'hffff, 16'h00ff};
    localparam logic [7:0] CMASK [3] =
        '{`TECT_CTRL_MASK_PSC, `TECT_CTRL_MASK_NOPSC, `TECT_CTRL_MASK_PSC};
    localparam int FBIT [3] =
        '{`TECT_FLAG0_BIT, `TECT_FLAG1_BIT, `TECT_FLAG2_BIT};

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : gen_cnt
            logic isrc;
            logic active;
            logic level_on;
            logic edge_in;
            logic wr_val;

            // RULE1 counter 0 internal source
            // RULE3 counter 2 internal source
            // RULE2 counter 1 divided by four
            if (g == 1)
            begin : gen_div
                assign isrc = (div4_q == 2'(`TECT_C1_DIV - 1));
            end
            else
            begin : gen_psc
                assign isrc = psc_tick(ctrl_q[g].psc, psc_q);
            end

            // RULE21 event edge select
            assign edge_in = ctrl_q[g].edge_sel ? pin_fall[g] : pin_rise[g];
            assign level_on = (pin_s2_q[g] == ctrl_q[g].edge_sel);
            assign wr_val = wr_hit[HI_IDX[g]];

            // RULE20 mode decode
            always_comb
            begin
                active = 1'b0;
                case (ctrl_q[g].mode)
                    // RULE10 event source is the pin
                    MODE_EVENT: active = ctrl_q[g].run && edge_in;
                    // RULE11 timer counts internal ticks
                    MODE_TIMER: active = ctrl_q[g].run && isrc;
                    // RULE12 count while level persists
                    MODE_PULSE: active = armed_q[g] && level_on && isrc;
                    default: active = 1'b0;
                endcase
            end
            assign tick[g] = active;

            // RULE9 control register
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    ctrl_q[g] <= tect_ctrl_t'(`TECT_CTRL_RESET);
                    armed_q[g] <= 1'b0;
                end
                else if (wr_hit[CT_IDX[g]])
                begin
                    ctrl_q[g] <= tect_ctrl_t'(wbyte_q & CMASK[g]);
                    armed_q[g] <= 1'b0;
                end
                else if (ctrl_q[g].mode == MODE_PULSE && ctrl_q[g].run)
                begin
                    // RULE18 start only on an edge
                    if (!armed_q[g] && (ctrl_q[g].edge_sel ? pin_rise[g]
                                                           : pin_fall[g]))
                    begin
                        armed_q[g] <= 1'b1;
                    end
                    // RULE16 stop and clear run
                    // RULE17 single measurement
                    else if (armed_q[g] && !level_on)
                    begin
                        armed_q[g] <= 1'b0;
                        ctrl_q[g].run <= 1'b0;
                    end
                end
            end

            // RULE13 RULE14 count up to terminal
            // RULE15 RULE19 overflow reloads
            // RULE22 load when stopped
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    cnt_q[g] <= 16'h0000;
                    pre_q[g] <= 16'h0000;
                end
                else
                begin
                    if (wr_val)
                    begin
                        // RULE5 RULE8 preload on value write
                        if (g == 2)
                        begin
                            pre_q[g] <= {8'h00, wbyte_q};
                        end
                        else
                        begin
                            pre_q[g] <= {wbyte_q, lowbuf_q[g == 1]};
                        end
                    end
                    if (wr_val && !ctrl_q[g].run)
                    begin
                        if (g == 2)
                        begin
                            cnt_q[g] <= {8'h00, wbyte_q};
                        end
                        else
                        begin
                            cnt_q[g] <= {wbyte_q, lowbuf_q[g == 1]};
                        end
                    end
                    else if (tick[g])
                    begin
                        if (cnt_q[g] == TOP[g])
                        begin
                            cnt_q[g] <= pre_q[g];
                        end
                        else
                        begin
                            cnt_q[g] <= cnt_q[g] + 16'h0001;
                        end
                    end
                end
            end

            // RULE15 overflow flag, set wins
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    flag_q[g] <= 1'b0;
                end
                else if (tick[g] && cnt_q[g] == TOP[g])
                begin
                    flag_q[g] <= 1'b1;
                end
                else if (wr_hit[8] && wbyte_q[FBIT[g]])
                begin
                    flag_q[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // RULE4 low write fills buffer
    // RULE6 high read latches low byte
    generate
        for (g = 0; g < 2; g++)
        begin : gen_buf
            always_ff @(posedge CLK or posedge RST)
            begin
                if (RST)
                begin
                    lowbuf_q[g] <= 8'h00;
                end
                else if (rd_go && rsel[HI_IDX[g]])
                begin
                    lowbuf_q[g] <= cnt_q[g][7:0];
                end
                else if (wr_hit[HI_IDX[g] + 1])
                begin
                    lowbuf_q[g] <= wbyte_q;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    logic [7:0] rd_byte;
    always_comb
    begin
        rd_byte = 8'h00;
        case (1'b1)
            rsel[0]: rd_byte = cnt_q[0][15:8];
            // RULE7 low read from buffer
            rsel[1]: rd_byte = lowbuf_q[0];
            rsel[2]: rd_byte = ctrl_q[0];
            rsel[3]: rd_byte = cnt_q[1][15:8];
            rsel[4]: rd_byte = lowbuf_q[1];
            rsel[5]: rd_byte = ctrl_q[1];
            // RULE8 read live counter 2
            rsel[6]: rd_byte = cnt_q[2][7:0];
            rsel[7]: rd_byte = ctrl_q[2];
            rsel[8]: rd_byte = 8'((flag_q[0] << `TECT_FLAG0_BIT)
                                | (flag_q[1] << `TECT_FLAG1_BIT)
                                | (flag_q[2] << `TECT_FLAG2_BIT));
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            ARREADY <= 1'b0;
            RVALID <= 1'b0;
            RDATA <= 32'h0000_0000;
            RRESP <= `TECT_RESP_OKAY;
        end
        else
        begin
            ARREADY <= !RVALID && !ARREADY;
            if (rd_go)
            begin
                RVALID <= 1'b1;
                RDATA <= {24'h00_0000, rd_byte};
                RRESP <= (rsel == '0) ? `TECT_RESP_SLVERR
                                      : `TECT_RESP_OKAY;
            end
            else if (RVALID && RREADY)
            begin
                RVALID <= 1'b0;
            end
        end
    end

    // Registered copies so every output leaves a flip-flop
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            COUNT0 <= '0;
            COUNT1 <= '0;
            COUNT2 <= '0;
            OVERFLOW <= 3'h0;
        end
        else
        begin
            COUNT0 <= cnt_q[0][CW0-1:0];
            COUNT1 <= cnt_q[1][CW0-1:0];
            COUNT2 <= cnt_q[2][CW2-1:0];
            OVERFLOW <= {tick[2] && cnt_q[2] == TOP[2],
                         tick[1] && cnt_q[1] == TOP[1],
                         tick[0] && cnt_q[0] == TOP[0]};
        end
    end

endmodule

/* File: tect_top_asserts.sv */
// Concurrent checks on the ports of the three-counter timer block.
// Assumes it is bound to tect_top and sees only that module's ports.
`timescale 1ns/10ps
`include "tect_params.svh"

module tect_top_asserts
    import tect_pkg::*;
#(
    parameter int CW0 = 16,
    parameter int CW2 = 8
)
(
    // Clock and reset
    input wire logic CLK,
    input wire logic RST,
    // Pins and counters
    input wire logic [2:0] CNT_PIN,
    input wire logic [CW0-1:0] COUNT0,
    input wire logic [CW0-1:0] COUNT1,
    input wire logic [CW2-1:0] COUNT2,
    input wire logic [2:0] OVERFLOW,
    // Write channels
    input wire logic AWVALID,
    input wire logic AWREADY,
    input wire logic [31:0] AWADDR,
    input wire logic WVALID,
    input wire logic WREADY,
    input wire logic [31:0] WDATA,
    input wire logic [3:0] WSTRB,
    input wire logic BVALID,
    input wire logic BREADY,
    input wire logic [1:0] BRESP,
    // Read channels
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [31:0] ARADDR,
    input wire logic RVALID,
    input wire logic RREADY,
    input wire logic [31:0] RDATA,
    input wire logic [1:0] RRESP
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    // ----------
    // Bus answers
    // ----------
    chk_write_answer: assert property (
        AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
        else $error("write response not two cycles after handshake");
    chk_read_answer: assert property (
        ARVALID && ARREADY |=> RVALID)
        else $error("read data not one cycle after handshake");
    chk_bresp_held: assert property (
        BVALID && !BREADY |=> BVALID && $stable(BRESP))
        else $error("write response dropped before taken");
    chk_rdata_held: assert property (
        RVALID && !RREADY |=> RVALID && $stable(RDATA))
        else $error("read data dropped before taken");
    chk_rdata_byte: assert property (
        RVALID |-> RDATA[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");
    chk_error_zero: assert property (
        RVALID && RRESP == `TECT_RESP_SLVERR |-> RDATA == 32'h0000_0000)
        else $error("refused read returned data");
    chk_write_block: assert property (
        BVALID |-> !AWREADY && !WREADY)
        else $error("write taken while response pending");
    chk_read_block: assert property (
        RVALID |-> !ARREADY)
        else $error("read taken while data pending");

    // ----------
    // Counters
    // ----------
    // Counter 1 ticks at most every second clock (every fourth off its divider), so pulses never abut
    chk_ovf1_single: assert property (
        OVERFLOW[1] |=> !OVERFLOW[1])
        else $error("counter 1 overflow pulse too long");
endmodule

/* File: tect_pin_model.sv */
// Far side model: drives the three counter input pins as plain levels.
// Assumes the bench calls its tasks; all changes land after a clock edge.
`timescale 1ns/10ps

module tect_pin_model
(
    // Clock
    input wire logic CLK,
    // Driven pins
    output logic [2:0] CNT_PIN
);
    initial CNT_PIN = 3'h0;

    // levels held several cycles so the synchroniser sees each
    task automatic level(input int i, input logic v, input int hold);
        begin
            @(posedge CLK);
            CNT_PIN[i] <= v;
            repeat (hold) @(posedge CLK);
        end
    endtask

    task automatic pulse(input int i, input logic v, input int len);
        begin
            level(i, v, len);
            level(i, !v, 4);
        end
    endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the three-counter timer block.
// Assumes tect_top, its checker and the pin model are compiled first.
`timescale 1ns/10ps
`include "tect_params.svh"

module tb_top;
    import tect_pkg::*;
    typedef struct packed
    {
        logic [7:0] a;
        logic [7:0] d;
        logic [1:0] r;
    } tect_row_t;

    logic CLK = 0;
    logic RST = 1;
    logic [2:0] CNT_PIN;
    logic [15:0] COUNT0, COUNT1;
    logic [7:0] COUNT2;
    logic [2:0] OVERFLOW;
    logic AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0;
    logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
    logic [31:0] AWADDR = 0, WDATA = 0, ARADDR = 0, RDATA;
    logic [3:0] WSTRB = 4'hf;
    logic [1:0] BRESP, RRESP, rr;
    logic [31:0] rdat;
    int error_cnt = 0, cmp_count = 0, cyc = 0, n, c;
    tect_row_t rows [0:10] = '{
        '{8'h30, 8'h00, `TECT_RESP_OKAY},
        '{8'h34, 8'h00, `TECT_RESP_OKAY},
        '{8'h38, 8'h08, `TECT_RESP_OKAY},
        '{8'h3c, 8'h00, `TECT_RESP_OKAY},
        '{8'h40, 8'h00, `TECT_RESP_OKAY},
        '{8'h44, 8'h08, `TECT_RESP_OKAY},
        '{8'hb0, 8'h00, `TECT_RESP_OKAY},
        '{8'hb4, 8'h08, `TECT_RESP_OKAY},
        '{8'hc0, 8'h00, `TECT_RESP_OKAY},
        '{8'h04, 8'h00, `TECT_RESP_SLVERR},
        '{8'h31, 8'h00, `TECT_RESP_SLVERR}};

    always #2.5 CLK = ~CLK;

    tect_top dut (.CLK, .RST, .CNT_PIN, .COUNT0, .COUNT1, .COUNT2,
        .OVERFLOW, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA,
        .WSTRB, .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR,
        .RVALID, .RREADY, .RDATA, .RRESP);
    tect_pin_model pins (.CLK(CLK), .CNT_PIN(CNT_PIN));

    task automatic test_done;
        begin
            $display("compares %0d mismatches %0d", cmp_count, error_cnt);
            if (error_cnt == 0 && cmp_count > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge CLK)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            test_done();
        end
    end

    task automatic chk(input string nm, input logic [31:0] e, g);
        begin
            cmp_count++;
            if (g !== e)
            begin
                error_cnt++;
                $display("CHECK FAILED %s exp %h got %h", nm, e, g);
            end
        end
    endtask

    // Offers address and data together; either may be taken first
    task automatic wr(input logic [31:0] a, d, output logic [1:0] r);
        logic b;
        begin
            b = 0;
            @(posedge CLK);
            AWADDR <= a;
            WDATA <= d;
            AWVALID <= 1;
            WVALID <= 1;
            BREADY <= 1;
            while (!b)
            begin
                @(posedge CLK);
                if (AWVALID && AWREADY)
                    AWVALID <= 0;
                if (WVALID && WREADY)
                    WVALID <= 0;
                if (BVALID === 1'b1)
                begin
                    r = BRESP;
                    BREADY <= 0;
                    b = 1;
                end
            end
        end
    endtask

    task automatic rd(input logic [31:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        begin
            @(posedge CLK);
            ARADDR <= a;
            ARVALID <= 1;
            RREADY <= 1;
            do
            begin
                @(posedge CLK);
                if (ARVALID && ARREADY)
                    ARVALID <= 0;
            end
            while (RVALID !== 1'b1);
            d = RDATA;
            r = RRESP;
            RREADY <= 0;
        end
    endtask

    task automatic w(input logic [31:0] a, d);
        wr(a, d, rr);
    endtask

    // Cycles between two overflow pulses of counter b
    task automatic meas(input int b, output int k);
        begin
            k = 0;
            @(posedge CLK);
            while (OVERFLOW[b] !== 1'b1)
                @(posedge CLK);
            do
            begin
                @(posedge CLK);
                k++;
            end
            while (OVERFLOW[b] !== 1'b1);
        end
    endtask

    initial
    begin
        repeat (6) @(posedge CLK);
        RST <= 0;
        repeat (2) @(posedge CLK);
        foreach (rows[i])
        begin
            rd(rows[i].a, rdat, rr);
            chk("reset value", rows[i].d, rdat);
            chk("read resp", rows[i].r, rr);
        end
        wr(8'h08, 8'h55, rr);
        chk("write resp", `TECT_RESP_SLVERR, rr);
        $display("test registers done");
        w(8'h34, 8'h34);
        chk("count0 low only", 0, COUNT0);
        w(8'h30, 8'h12);
        repeat (2) @(posedge CLK);
        chk("count0 load", 16'h1234, COUNT0);
        w(8'h34, 8'h99);
        rd(8'h34, rdat, rr);
        chk("low buffer", 8'h99, rdat);
        rd(8'h30, rdat, rr);
        chk("high read", 8'h12, rdat);
        rd(8'h34, rdat, rr);
        chk("low latched", 8'h34, rdat);
        $display("test byte buffer done");
        w(8'h34, 8'hff);
        w(8'h30, 8'hff);
        for (c = 0; c < 8; c++)
        begin
            w(8'h38, 8'h90 | c);
            meas(0, n);
            meas(0, n);
            chk("count0 period", 1 << c, n);
        end
        w(8'h40, 8'hff);
        w(8'h3c, 8'hff);
        w(8'h44, 8'h90);
        meas(1, n);
        meas(1, n);
        chk("count1 period", 4, n);
        w(8'hb0, 8'hff);
        w(8'hb4, 8'h91);
        meas(2, n);
        meas(2, n);
        chk("count2 period", 2, n);
        w(8'h44, 8'h80);
        w(8'hb4, 8'h80);
        rd(8'hc0, rdat, rr);
        chk("flags set", 8'h70, rdat);
        w(8'hc0, 8'h50);
        rd(8'hc0, rdat, rr);
        chk("flags cleared", 0, rdat & 8'h50);
        $display("test timer periods done");
        meas(0, n);
        w(8'h34, 8'h00);
        w(8'h30, 8'h10);
        rd(8'h30, rdat, rr);
        chk("running keeps count", 8'hff, rdat);
        // Only the next overflow: the one after would take far too long
        while (OVERFLOW[0] !== 1'b1)
            @(posedge CLK);
        repeat (2) @(posedge CLK);
        chk("reload preload", 16'h1000, COUNT0);
        w(8'h38, 8'h80);
        $display("test running preload done");
        w(8'h40, 8'h00);
        w(8'h3c, 8'h00);
        w(8'h44, 8'h50);
        repeat (3) pins.pulse(1, 1, 4);
        repeat (6) @(posedge CLK);
        chk("rising events", 3, COUNT1);
        w(8'h44, 8'h58);
        pins.level(1, 1, 6);
        chk("rise ignored", 3, COUNT1);
        pins.level(1, 0, 6);
        chk("falling event", 4, COUNT1);
        $display("test events done");
        w(8'hb0, 8'h00);
        pins.level(2, 1, 2);
        w(8'hb4, 8'hd8);
        repeat (10) @(posedge CLK);
        chk("no start on level", 0, COUNT2);
        pins.level(2, 0, 5);
        pins.level(2, 1, 20);
        pins.level(2, 0, 8);
        chk("pulse width", 1, COUNT2 >= 19 && COUNT2 <= 21);
        rd(8'hb4, rdat, rr);
        chk("run cleared", 8'hc8, rdat);
        n = COUNT2;
        pins.pulse(2, 1, 10);
        chk("result kept", n, COUNT2);
        w(8'hb0, 8'hf8);
        w(8'hb4, 8'hd8);
        pins.pulse(2, 1, 30);
        rd(8'hc0, rdat, rr);
        chk("pulse overflow", 1, rdat[4]);
        $display("test pulse width done");
        @(posedge CLK);
        RST <= 1;
        repeat (2) @(posedge CLK);
        RST <= 0;
        rd(8'h38, rdat, rr);
        chk("ctrl after reset", 8'h08, rdat);
        chk("count after reset", 0, COUNT1);
        $display("test second reset done");
        test_done();
    end
endmodule

bind tect_top tect_top_asserts #(.CW0(CW0), .CW2(CW2)) u_chk (.CLK,
    .RST, .CNT_PIN, .COUNT0, .COUNT1, .COUNT2, .OVERFLOW, .AWVALID,
    .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB, .BVALID, .BREADY,
    .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP);
